/* File: design/cds_sar.sv */
// Ten bit successive approximation register, MSB first
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_sar #(
  parameter int Bits = 10
) (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            start,
  input  wire logic            abort,
  input  wire logic            compHigh,
  output var  logic            busy,
  output var  logic            done,
  output var  logic [Bits-1:0] value
);
  typedef struct packed {
    logic            busy;
    logic            done;
    logic [Bits-1:0] val;
    logic [Bits-1:0] probe;
  } cds_sar_type;
  cds_sar_type state_reg;
  cds_sar_type state_next;

  always_comb begin
    state_next = state_reg;
    state_next.done = 1'b0;
    if (start) begin
      state_next.busy = 1'b1;
      state_next.val = '0;
      state_next.probe = {1'b1, {(Bits-1){1'b0}}};
    end else if (state_reg.busy && abort) begin
      state_next.busy = 1'b0;
    end else if (state_reg.busy) begin
      if (compHigh) begin
        state_next.val = state_reg.val | state_reg.probe;
      end
      state_next.probe = state_reg.probe >> 1;
      if (state_reg.probe[0]) begin
        state_next.busy = 1'b0;
        state_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign done = state_reg.done;
  assign value = state_reg.val;
endmodule : cds_sar
`default_nettype wire

/* File: design/cds_sequencer.sv */
// Capacitive divider sequencer with register port and pin controls
// Functional notes
// - Extra capacitance select adds to hold capacitor
// - Extra capacitance disconnected during conversion
// - Either bus-out enable connects bus to pin
// - Override drives monitor pin in pre-charge
// - No monitor pin override outside pre-charge
// - Pre-charge, acquisition last programmed 1-127 timer steps (4-clock instruction cycles or RC ticks)
// - RC clock option paces the stage timers
// - Ten bit result MSB first from zero
// - First result pair 0, second pair 1
// - Each pair held zero during its conversion
// - Second pair zeroed only while the second sample converts
// - Status code per stage, zero at end
// - Zero pre-charge count skips pre-charge
// - Completion clears go, sets flag, updates results
// - Second sample inverts polarities, stored bits unchanged
// - Second sample starts two cycles after first conversion
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_sequencer
  import cds_pkg::*;
#(
  parameter int Bits = 10
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [`CDS_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output var  logic [15:0]           regRdata,
  input  wire logic                  rcTick,
  input  wire logic                  eventTrigger,
  input  wire logic                  compHigh,
  output var  logic [2:0]            extraCapSelect,
  output var  logic                  extraCapConnect,
  output var  logic                  busOutStdEnable,
  output var  logic                  busOutLowzEnable,
  output var  logic                  monitorPinOut,
  output var  logic                  monitorPinOverride,
  output var  logic                  holdChargeHigh,
  output var  logic                  channelDriveHigh,
  output var  logic                  channelDriveEnable,
  output var  logic                  channelToHold,
  output var  logic                  guardLevel,
  output var  logic [2:0]            phaseStatus,
  output var  logic                  converterIntFlag,
  output var  logic                  convGo
);
  typedef struct packed {
    cds_phase_type   phase;
    logic            second;
    logic [6:0]      count;
    logic [2:0]      instruction_cycle_time;
    logic [1:0]      gap;
    logic            enable;
    logic            go;
    logic            trigEn;
    logic            trigPrev;
    logic            rcSel;
    logic [7:0]      ctrl3;
    logic            guardPol;
    logic [6:0]      preCount;
    logic [6:0]      acqCount;
    logic [2:0]      capSel;
    logic [Bits-1:0] res0;
    logic [Bits-1:0] res1;
    logic            intFlag;
    logic            sarStart;
    logic [15:0]     rdata;
    logic [2:0]      stat;
  } cds_seq_type;
  cds_seq_type state_reg;
  cds_seq_type state_next;

  logic            sarBusy;
  logic            sarDone;
  logic [Bits-1:0] sarValue;

  cds_sar #(.Bits(Bits)) sarUnit (
    .clk      (clk),
    .rst      (rst),
    .start    (state_reg.sarStart),
    .abort    (!state_reg.go),
    .compHigh (compHigh),
    .busy     (sarBusy),
    .done     (sarDone),
    .value    (sarValue)
  );

  // Status code for a phase of the first or second sample
  function automatic logic [2:0] statCode(input cds_phase_type ph, input logic sec);
    logic [2:0] code;
    code = `CDS_ST_IDLE;
    unique case (ph)
      CDS_IDLE: code = `CDS_ST_IDLE;
      CDS_PRE:  code = sec ? `CDS_ST_PRE2 : `CDS_ST_PRE1;
      CDS_ACQ:  code = sec ? `CDS_ST_ACQ2 : `CDS_ST_ACQ1;
      CDS_CNV:  code = sec ? `CDS_ST_CNV2 : `CDS_ST_CNV1;
      CDS_GAP:  code = `CDS_ST_CNV1;
    endcase
    return code;
  endfunction : statCode

  logic tick;
  logic startReq;
  logic invNow;
  logic goWrite;

  always_comb begin
    state_next = state_reg;
    state_next.sarStart = 1'b0;
    // Timer step: instruction cycle, or RC tick when RC is conversion clock
    tick = state_reg.rcSel ? rcTick : (state_reg.instruction_cycle_time == `CDS_INSTRUCTION_CYCLE_TIME_CYCLES - 3'd1);
    state_next.instruction_cycle_time = (state_reg.instruction_cycle_time == `CDS_INSTRUCTION_CYCLE_TIME_CYCLES - 3'd1) ? 3'd0
                     : state_reg.instruction_cycle_time + 3'd1;
    goWrite = regWrite && (regAddr == `CDS_OFF_CTRL0) && regWdata[`CDS_B_GO];
    startReq = state_reg.enable && (state_reg.phase == CDS_IDLE)
             && (goWrite || (state_reg.trigEn && eventTrigger && !state_reg.trigPrev));
    state_next.trigPrev = eventTrigger;

    // Register writes
    if (regWrite) begin
      unique case (regAddr)
        `CDS_OFF_CTRL0: begin
          state_next.enable = regWdata[`CDS_B_ON];
          if (!regWdata[`CDS_B_GO]) begin
            state_next.go = 1'b0;
          end
        end
        `CDS_OFF_CTRL1: begin
          state_next.rcSel = regWdata[`CDS_B_RC];
          state_next.trigEn = regWdata[`CDS_B_TRIG];
          state_next.guardPol = regWdata[`CDS_B_GPOL];
        end
        `CDS_OFF_CTRL3: state_next.ctrl3 = regWdata;
        `CDS_OFF_PRE:   state_next.preCount = regWdata[6:0];
        `CDS_OFF_ACQ:   state_next.acqCount = regWdata[6:0];
        `CDS_OFF_CAP:   state_next.capSel = regWdata[2:0];
        `CDS_OFF_STAT:  state_next.intFlag = regWdata[`CDS_B_FLAG] & state_reg.intFlag;
        default: ;
      endcase
    end

    // Sequencer
    unique case (state_reg.phase)
      CDS_IDLE: begin
        if (startReq) begin
          state_next.go = 1'b1;
          state_next.second = 1'b0;
          state_next.instruction_cycle_time = 3'd0;
          if (state_reg.preCount != 7'd0) begin
            state_next.phase = CDS_PRE;
            state_next.count = state_reg.preCount;
          end else begin
            state_next.phase = CDS_ACQ;
            state_next.count = state_reg.acqCount;
          end
        end
      end
      CDS_PRE, CDS_ACQ: begin
        if (tick) begin
          if (state_reg.count > 7'd1) begin
            state_next.count = state_reg.count - 7'd1;
          end else if (state_reg.phase == CDS_PRE && state_reg.acqCount != 7'd0) begin
            state_next.phase = CDS_ACQ;
            state_next.count = state_reg.acqCount;
          end else begin
            state_next.phase = CDS_CNV;
            state_next.sarStart = 1'b1;
          end
        end
      end
      CDS_CNV: begin
        if (sarDone) begin
          if (state_reg.second) begin
            state_next.res1 = sarValue;
            state_next.phase = CDS_IDLE;
            state_next.go = 1'b0;
            state_next.intFlag = 1'b1;
          end else begin
            state_next.res0 = sarValue;
            if (state_reg.ctrl3[`CDS_B_DS]) begin
              state_next.phase = CDS_GAP;
              state_next.gap = `CDS_GAP_CYCLES - 2'd1;
            end else begin
              state_next.phase = CDS_IDLE;
              state_next.go = 1'b0;
              state_next.intFlag = 1'b1;
            end
          end
        end
      end
      CDS_GAP: begin
        if (state_reg.gap != 2'd0) begin
          state_next.gap = state_reg.gap - 2'd1;
        end else begin
          state_next.second = 1'b1;
          state_next.instruction_cycle_time = 3'd0;
          if (state_reg.preCount != 7'd0) begin
            state_next.phase = CDS_PRE;
            state_next.count = state_reg.preCount;
          end else begin
            state_next.phase = CDS_ACQ;
            state_next.count = state_reg.acqCount;
          end
        end
      end
    endcase

    // Zero the pair being converted
    if (state_next.sarStart) begin
      if (state_reg.second) begin
        state_next.res1 = `CDS_RES_ZERO;
      end else begin
        state_next.res0 = `CDS_RES_ZERO;
      end
    end

    // Abort by clearing go, or by turning the converter off
    if (state_reg.phase != CDS_IDLE && (!state_next.go || !state_next.enable)) begin
      if (state_reg.phase == CDS_CNV) begin
        if (state_reg.second) state_next.res1 = sarValue;
        else state_next.res0 = sarValue;
      end
      state_next.phase = CDS_IDLE;
      state_next.go = 1'b0;
    end

    state_next.stat = statCode(state_next.phase, state_next.second);
    // From next state, so pins flip with the first cycle of the second sample
    invNow = state_next.second && (state_next.phase != CDS_IDLE)
           && state_reg.ctrl3[`CDS_B_INV];

    state_next.rdata = 16'h0000;
    if (regRead) begin
      unique case (regAddr)
        `CDS_OFF_CTRL0: state_next.rdata = {14'h0000, state_reg.go, state_reg.enable};
        `CDS_OFF_CTRL1: state_next.rdata = {13'h0000, state_reg.guardPol,
                                            state_reg.trigEn, state_reg.rcSel};
        `CDS_OFF_CTRL3: state_next.rdata = {8'h00, state_reg.ctrl3};
        `CDS_OFF_STAT:  state_next.rdata = {12'h000, state_reg.intFlag, state_reg.stat};
        `CDS_OFF_PRE:   state_next.rdata = {9'h000, state_reg.preCount};
        `CDS_OFF_ACQ:   state_next.rdata = {9'h000, state_reg.acqCount};
        `CDS_OFF_CAP:   state_next.rdata = {13'h0000, state_reg.capSel};
        `CDS_OFF_RES0:  state_next.rdata = {{(16-Bits){1'b0}}, state_reg.res0};
        `CDS_OFF_RES1:  state_next.rdata = {{(16-Bits){1'b0}}, state_reg.res1};
        default:        state_next.rdata = 16'h0000;
      endcase
    end
    // Interrupt flag set wins over a software clear in the same cycle
    if (state_reg.intFlag && !state_next.intFlag && regWrite
        && regAddr == `CDS_OFF_STAT && state_reg.phase == CDS_CNV && sarDone
        && (state_reg.second || !state_reg.ctrl3[`CDS_B_DS])) begin
      state_next.intFlag = 1'b1;
    end
  end

  // Pin controls are registered so every output leaves a flip-flop
  typedef struct packed {
    logic capOn;
    logic ovr;
    logic pinOut;
    logic holdHigh;
    logic chanHigh;
    logic chanDrive;
    logic chanHold;
    logic guard;
  } cds_pins_type;
  cds_pins_type pins_reg;
  cds_pins_type pins_next;

  always_comb begin
    pins_next = '0;
    // Hold capacitor gets extra capacitance, but never while converting
    pins_next.capOn = (state_next.phase != CDS_CNV) && (state_next.capSel != 3'd0);
    pins_next.ovr = state_reg.ctrl3[`CDS_B_OVR] && (state_next.phase == CDS_PRE);
    pins_next.pinOut = pins_next.ovr && (state_reg.ctrl3[`CDS_B_IPOL] ^ invNow);
    pins_next.holdHigh = state_reg.ctrl3[`CDS_B_IPOL] ^ invNow;
    pins_next.chanHigh = state_reg.ctrl3[`CDS_B_EPOL] ^ invNow;
    pins_next.chanDrive = (state_next.phase == CDS_PRE);
    pins_next.chanHold = (state_next.phase == CDS_ACQ);
    pins_next.guard = state_reg.guardPol ^ invNow ^ (state_next.phase == CDS_ACQ);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
      pins_reg <= '0;
    end else begin
      state_reg <= state_next;
      pins_reg <= pins_next;
    end
  end

  assign regRdata = state_reg.rdata;
  assign extraCapSelect = state_reg.capSel;
  assign extraCapConnect = pins_reg.capOn;
  assign busOutStdEnable = state_reg.ctrl3[`CDS_B_STD];
  assign busOutLowzEnable = state_reg.ctrl3[`CDS_B_LOWZ];
  assign monitorPinOut = pins_reg.pinOut;
  assign monitorPinOverride = pins_reg.ovr;
  assign holdChargeHigh = pins_reg.holdHigh;
  assign channelDriveHigh = pins_reg.chanHigh;
  assign channelDriveEnable = pins_reg.chanDrive;
  assign channelToHold = pins_reg.chanHold;
  assign guardLevel = pins_reg.guard;
  assign phaseStatus = state_reg.stat;
  assign converterIntFlag = state_reg.intFlag;
  assign convGo = state_reg.go;
endmodule : cds_sequencer
`default_nettype wire

/* File: shared/cds_cfg.svh */
// Constants for the capacitive divider sequencer
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH
`define CDS_ADDR_W        4
`define CDS_OFF_CTRL0     4'h0
`define CDS_OFF_CTRL3     4'h1
`define CDS_OFF_STAT      4'h2
`define CDS_OFF_PRE       4'h3
`define CDS_OFF_ACQ       4'h4
`define CDS_OFF_CAP       4'h5
`define CDS_OFF_RES0      4'h6
`define CDS_OFF_RES1      4'h7
`define CDS_OFF_CTRL1     4'h8
`define CDS_B_ON          0
`define CDS_B_GO          1
`define CDS_B_DS          0
`define CDS_B_INV         1
`define CDS_B_OVR         3
`define CDS_B_STD         4
`define CDS_B_LOWZ        5
`define CDS_B_IPOL        6
`define CDS_B_EPOL        7
`define CDS_B_GPOL        2
`define CDS_B_RC          0
`define CDS_B_TRIG        1
`define CDS_B_FLAG        0
`define CDS_ST_IDLE       3'b000
`define CDS_ST_PRE1       3'b001
`define CDS_ST_ACQ1       3'b011
`define CDS_ST_CNV1       3'b010
`define CDS_ST_PRE2       3'b101
`define CDS_ST_ACQ2       3'b111
`define CDS_ST_CNV2       3'b110
`define CDS_GAP_CYCLES    2'd2
`define CDS_INSTRUCTION_CYCLE_TIME_CYCLES  3'd4
`define CDS_RES_ZERO      10'h000
`endif

/* File: shared/cds_pkg.sv */
// Types for the capacitive divider sequencer
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_IDLE, CDS_PRE, CDS_ACQ, CDS_CNV, CDS_GAP
  } cds_phase_type;
endpackage : cds_pkg

/* File: tb/cds_sensor_model.sv */
// Sensor electrode model holding the charge left by pre-charge
`timescale 1ns/1ps
`default_nettype none
module cds_sensor_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic channelDriveEnable,
  input  wire logic channelDriveHigh,
  output var  logic compHigh
);
  logic chargeReg;
  // Charge level decides every comparison of the next conversion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) chargeReg <= 1'b0;
    else if (channelDriveEnable) chargeReg <= channelDriveHigh;
  end
  assign compHigh = chargeReg;
endmodule : cds_sensor_model
`default_nettype wire

/* File: tb/cds_sequencer_sva.sv */
// Port checks for the capacitive divider sequencer
`timescale 1ns/1ps
`default_nettype none
module cds_sequencer_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [2:0] extraCapSelect,
  input wire logic       extraCapConnect,
  input wire logic       monitorPinOut,
  input wire logic       monitorPinOverride,
  input wire logic       holdChargeHigh,
  input wire logic       channelDriveEnable,
  input wire logic       channelToHold,
  input wire logic [2:0] phaseStatus,
  input wire logic       converterIntFlag,
  input wire logic       convGo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence seqEnd;
    phaseStatus == 3'b000 && $past(phaseStatus) != 3'b000;
  endsequence
  sequence seqEnter2;
    phaseStatus inside {3'b101, 3'b111} && !($past(phaseStatus) inside {3'b101, 3'b111});
  endsequence
  a_cap_sel_gate: assert property (extraCapConnect |-> extraCapSelect != 3'h0)
    else $error("extra cap connected with zero select");
  a_cap_off_conv: assert property (phaseStatus == 3'b110 |-> !extraCapConnect)
    else $error("extra cap connected during conversion");
  a_ovr_pre_only: assert property (monitorPinOverride |-> phaseStatus inside {3'b001, 3'b101})
    else $error("monitor override outside pre-charge");
  a_ovr_level: assert property (monitorPinOverride |-> monitorPinOut == holdChargeHigh)
    else $error("monitor drive level wrong");
  a_status_code: assert property (phaseStatus != 3'b100)
    else $error("illegal status code");
  a_go_start: assert property ($rose(convGo) |-> ##[0:1] phaseStatus inside {3'b001, 3'b011})
    else $error("sequence did not start in pre-charge or acquisition");
  a_stage_pins: assert property ((channelDriveEnable |-> phaseStatus inside {3'b001, 3'b101})
    and (channelToHold |-> phaseStatus inside {3'b011, 3'b111}))
    else $error("stage pins disagree with status");
  a_done_flags: assert property (seqEnd |-> ##[0:1] (!convGo && converterIntFlag))
    else $error("completion flags wrong");
  a_second_gap: assert property (seqEnter2 |-> $past(phaseStatus) == 3'b010
    && $past(phaseStatus, 2) == 3'b010 && $past(phaseStatus, 3) == 3'b010)
    else $error("second sample started without gap");
endmodule : cds_sequencer_sva
bind cds_sequencer cds_sequencer_sva u_sva (.clk(clk), .rst(rst),
  .extraCapSelect(extraCapSelect), .extraCapConnect(extraCapConnect),
  .monitorPinOut(monitorPinOut), .monitorPinOverride(monitorPinOverride),
  .holdChargeHigh(holdChargeHigh), .channelDriveEnable(channelDriveEnable),
  .channelToHold(channelToHold), .phaseStatus(phaseStatus),
  .converterIntFlag(converterIntFlag), .convGo(convGo));
`default_nettype wire

/* File: tb/cds_sequencer_tb_top.sv */
// Testbench for the capacitive divider sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cds_cfg.svh"
module cds_sequencer_tb_top;
  logic        clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic        rcTick = 1'b0, eventTrigger = 1'b0, compHigh;
  logic [3:0]  regAddr = 4'h0, pAddr = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic [15:0] regRdata;
  logic [2:0]  extraCapSelect, phaseStatus;
  logic        extraCapConnect, busOutStdEnable, busOutLowzEnable, monitorPinOut;
  logic        monitorPinOverride, holdChargeHigh, channelDriveHigh, channelDriveEnable;
  logic        channelToHold, guardLevel, converterIntFlag, convGo;
  int          n_fail = 0, checks = 0, cyc = 0;
  int          cnt[8];
  logic [1:0]  gAcq = 2'b00;
  cds_sequencer uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .rcTick(rcTick),
    .eventTrigger(eventTrigger), .compHigh(compHigh), .extraCapSelect(extraCapSelect),
    .extraCapConnect(extraCapConnect), .busOutStdEnable(busOutStdEnable),
    .busOutLowzEnable(busOutLowzEnable), .monitorPinOut(monitorPinOut),
    .monitorPinOverride(monitorPinOverride), .holdChargeHigh(holdChargeHigh),
    .channelDriveHigh(channelDriveHigh), .channelDriveEnable(channelDriveEnable),
    .channelToHold(channelToHold), .guardLevel(guardLevel), .phaseStatus(phaseStatus),
    .converterIntFlag(converterIntFlag), .convGo(convGo));
  cds_sensor_model u_sensor (.clk(clk), .rst(rst), .channelDriveEnable(channelDriveEnable),
    .channelDriveHigh(channelDriveHigh), .compHigh(compHigh));
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    rcTick <= (cyc % 7 == 0);
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    regAddr <= a; regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp, what);
  endtask : rd
  // Counts cycles per status code; probe reads a result as its conversion begins
  task automatic run(input logic probe);
    logic [2:0] prev;
    logic       want, chkNow, ended;
    prev = 3'b000; want = 1'b0; chkNow = 1'b0; ended = 1'b0;
    cnt = '{default: 0};
    gAcq = 2'b10;
    // Sample first: the cycle right after the go write is already pre-charge
    for (int i = 0; i < 3000; i++) begin
      #1;
      if (chkNow) chk(regRdata, 16'h0000, "result during conversion");
      chkNow = want;
      want = 1'b0;
      cnt[phaseStatus]++;
      if (phaseStatus[1:0] == 2'b11) gAcq[phaseStatus[2]] = guardLevel;
      if (probe && phaseStatus != prev && phaseStatus[1:0] == 2'b10) begin
        pAddr = phaseStatus[2] ? `CDS_OFF_RES1 : `CDS_OFF_RES0;
        want = 1'b1;
      end
      if (phaseStatus == 3'b000 && prev != 3'b000) begin
        ended = 1'b1;
        break;
      end
      prev = phaseStatus;
      @(posedge clk);
      regRead <= want;
      regAddr <= pAddr;
    end
    chk(16'(ended), 16'h0001, "sequence ended");
  endtask : run
  task automatic t_regs;
    rd(4'hF, 16'h0000, "unmapped read");
    wr(`CDS_OFF_CAP, 8'h05);
    wr(`CDS_OFF_CTRL3, 8'h30);
    repeat (2) @(posedge clk);
    #1 chk(16'(extraCapSelect), 16'h0005, "cap select");
    chk(16'({busOutStdEnable, busOutLowzEnable}), 16'h0003, "bus out enables");
    chk(16'(extraCapConnect), 16'h0001, "extra cap connected");
    chk(16'(monitorPinOverride), 16'h0000, "no override with bus out");
    $display("test regs done");
  endtask : t_regs
  task automatic t_single;
    wr(`CDS_OFF_CTRL0, 8'h01);
    wr(`CDS_OFF_PRE, 8'h01);
    wr(`CDS_OFF_ACQ, 8'h02);
    wr(`CDS_OFF_CTRL3, 8'hC8);
    wr(`CDS_OFF_CTRL0, 8'h03);
    run(1'b0);
    chk(16'(cnt[1]), 16'h0004, "pre-charge cycles");
    chk(16'(cnt[3]), 16'h0008, "acquisition cycles");
    rd(`CDS_OFF_CTRL0, 16'h0001, "go after done");
    rd(`CDS_OFF_STAT, 16'h0008, "status after done");
    rd(`CDS_OFF_RES0, 16'h03FF, "single result");
    wr(`CDS_OFF_STAT, 8'h00);
    rd(`CDS_OFF_STAT, 16'h0000, "flag cleared");
    $display("test single done");
  endtask : t_single
  task automatic t_skip_trig;
    wr(`CDS_OFF_PRE, 8'h00);
    wr(`CDS_OFF_CTRL1, 8'h02);
    @(posedge clk);
    eventTrigger <= 1'b1;
    run(1'b0);
    @(posedge clk);
    eventTrigger <= 1'b0;
    chk(16'(cnt[1]), 16'h0000, "skipped pre-charge");
    chk(16'(cnt[3]), 16'h0008, "acquisition after trigger");
    wr(`CDS_OFF_CTRL1, 8'h00);
    $display("test skip done");
  endtask : t_skip_trig
  task automatic t_rc;
    wr(`CDS_OFF_PRE, 8'h03);
    wr(`CDS_OFF_CTRL1, 8'h01);
    wr(`CDS_OFF_CTRL0, 8'h03);
    run(1'b0);
    // Three ticks seven cycles apart, the first within seven cycles
    chk(16'(cnt[1] >= 15 && cnt[1] <= 21), 16'h0001, "rc paced pre-charge");
    wr(`CDS_OFF_CTRL1, 8'h00);
    $display("test rc done");
  endtask : t_rc
  task automatic t_double(input logic [7:0] ctl, input logic [15:0] e0, input logic [15:0] e1);
    wr(`CDS_OFF_PRE, 8'h01);
    wr(`CDS_OFF_ACQ, 8'h01);
    wr(`CDS_OFF_CTRL3, ctl);
    wr(`CDS_OFF_CTRL0, 8'h03);
    run(1'b1);
    chk(16'(cnt[5]), 16'h0004, "second pre-charge");
    chk(16'(gAcq), 16'h0001, "guard in acquisitions");
    rd(`CDS_OFF_RES0, e0, "first result");
    rd(`CDS_OFF_RES1, e1, "second result");
    $display("test double done");
  endtask : t_double
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_single();
    t_skip_trig();
    t_rc();
    t_double(8'h03, 16'h0000, 16'h03FF);
    t_double(8'h83, 16'h03FF, 16'h0000);
    summarize();
  end
endmodule : cds_sequencer_tb_top
`default_nettype wire
